/* serdes_port_clocking.sv */
// parallel host port clocking, mode select and receive output staging
// assumes external clocks arrive unsynchronised and are sampled on mclk
//
// The AXI4-Lite register port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module serdes_port_clocking (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [3:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [3:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic reference_clock_in,
  input wire logic tx_input_clock,
  input wire logic rxRecoveredClock,
  input wire logic [7:0] tx_parallel_data,
  input wire logic [1:0] tx_char_control,
  output logic txBufferReady,
  output logic [9:0] txCharOut,
  output logic txCharValid,
  input wire logic txEncoderReady,
  output logic [8:0] txModeOneHot,
  output logic [4:0] txBitClockMult,
  output logic tx_synth_clock_out,
  input wire logic [9:0] rxCharIn,
  input wire logic rxCharComma,
  input wire logic [7:0] rxDecodedData,
  input wire logic [2:0] rxDecodedStatus,
  input wire logic rxCharStrobe,
  output logic [7:0] rx_parallel_data,
  output logic [2:0] rx_char_status,
  output logic rx_char_clock_out
);
  // ************************************************************
  // register bus
  // ************************************************************
  logic [31:0] config_r;
  logic overflow_r;
  logic [3:0] awAddr_r;
  logic awHeld_r;
  logic [31:0] wData_r;
  logic [3:0] wStrb_r;
  logic wHeld_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  wire awTake = awvalid && awready;
  wire wTake = wvalid && wready;
  wire arTake = arvalid && arready;
  wire wrFire = awHeld_r && wHeld_r && !bvalid_r;
  wire wrConfig = wrFire && (awAddr_r == serdes_port_pkg::ADDR_CONFIG);
  wire wrStatus = wrFire && (awAddr_r == serdes_port_pkg::ADDR_STATUS);
  wire wrMapped = wrConfig || wrStatus;
  wire [31:0] strbMask = {{8{wStrb_r[3]}}, {8{wStrb_r[2]}}, {8{wStrb_r[1]}}, {8{wStrb_r[0]}}};
  wire [31:0] usedMask = (32'h1 << serdes_port_pkg::CFG_USED_BITS) - 32'h1;
  wire [31:0] config_nxt = ((config_r & ~strbMask) | (wData_r & strbMask)) & usedMask;
  wire clearOverflow = wrStatus && wStrb_r[0] && wData_r[serdes_port_pkg::ST_OVERFLOW_BIT];

  assign awready = !awHeld_r;
  assign wready = !wHeld_r;
  assign arready = !rvalid_r;
  assign bvalid = bvalid_r;
  assign bresp = bresp_r;
  assign rvalid = rvalid_r;
  assign rdata = rdata_r;
  assign rresp = rresp_r;

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      awHeld_r <= 1'b0;
      awAddr_r <= 4'h0;
      wHeld_r <= 1'b0;
      wData_r <= 32'h0000_0000;
      wStrb_r <= 4'h0;
    end else begin
      if (awTake) begin
        awHeld_r <= 1'b1;
        awAddr_r <= awaddr;
      end else if (wrFire) begin
        awHeld_r <= 1'b0;
      end
      if (wTake) begin
        wHeld_r <= 1'b1;
        wData_r <= wdata;
        wStrb_r <= wstrb;
      end else if (wrFire) begin
        wHeld_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      bvalid_r <= 1'b0;
      bresp_r <= serdes_port_pkg::RESP_OKAY;
      config_r <= serdes_port_pkg::CONFIG_RESET;
    end else begin
      if (wrFire) begin
        bvalid_r <= 1'b1;
        bresp_r <= wrMapped ? serdes_port_pkg::RESP_OKAY : serdes_port_pkg::RESP_SLVERR;
      end else if (bready) begin
        bvalid_r <= 1'b0;
      end
      if (wrConfig) begin
        config_r <= config_nxt;
      end
    end
  end

  // ************************************************************
  // configuration decode
  // ************************************************************
  wire [1:0] txClkSel = serdes_port_pkg::ternLevel(config_r[1:0]);
  wire [1:0] modeSel0 = serdes_port_pkg::ternLevel(config_r[5:4]);
  wire [1:0] modeSel1 = serdes_port_pkg::ternLevel(config_r[7:6]);
  wire [1:0] rxClkSel = serdes_port_pkg::ternLevel(config_r[9:8]);
  wire [1:0] decoder_mode_select = serdes_port_pkg::ternLevel(config_r[11:10]);
  wire rateHigh = config_r[serdes_port_pkg::CFG_RATE_BIT];
  wire phaseHold = config_r[serdes_port_pkg::CFG_PHRST_BIT];
  // forbidden combination falls back to the reference clock path
  wire invalidCfg = rateHigh && (txClkSel != serdes_port_pkg::LVL_LOW);
  wire useTxClk = (txClkSel != serdes_port_pkg::LVL_LOW) && !invalidCfg;
  wire [3:0] modeIdx = {2'h0, modeSel1} * 4'h3 + {2'h0, modeSel0};

  genvar gi;
  generate
    for (gi = 0; gi < serdes_port_pkg::MODE_COUNT; gi++) begin : g_mode
      assign txModeOneHot[gi] = (modeIdx == 4'(gi));
    end
  endgenerate

  assign txBitClockMult = rateHigh ? serdes_port_pkg::MULT_HALF_RATE
                                   : serdes_port_pkg::MULT_FULL_RATE;

  // ************************************************************
  // pin synchronisers and edge detection
  // ************************************************************
  logic [2:0] refSync_r;
  logic [2:0] txClkSync_r;
  logic [2:0] rxClkSync_r;
  logic [9:0] txPinMeta_r;
  logic [9:0] txPinSync_r;
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      refSync_r <= 3'h0;
      txClkSync_r <= 3'h0;
      rxClkSync_r <= 3'h0;
      txPinMeta_r <= 10'h000;
      txPinSync_r <= 10'h000;
    end else begin
      refSync_r <= {refSync_r[1:0], reference_clock_in};
      txClkSync_r <= {txClkSync_r[1:0], tx_input_clock};
      rxClkSync_r <= {rxClkSync_r[1:0], rxRecoveredClock};
      txPinMeta_r <= {tx_char_control, tx_parallel_data};
      txPinSync_r <= txPinMeta_r;
    end
  end
  wire refRise = refSync_r[1] && !refSync_r[2];
  wire refFall = !refSync_r[1] && refSync_r[2];
  wire txClkRise = txClkSync_r[1] && !txClkSync_r[2];
  wire rxClkRise = rxClkSync_r[1] && !rxClkSync_r[2];
  wire charTick = refRise || (rateHigh && refFall);
  wire captureEdge = useTxClk ? txClkRise : charTick;

  // ************************************************************
  // phase alignment
  // ************************************************************
  serdes_port_pkg::phase_state_e phState_r;
  serdes_port_pkg::phase_state_e phState_nxt;
  logic [7:0] phaseCnt_r;
  logic [7:0] phaseOffset_r;
  always_comb begin
    case (phState_r)
      serdes_port_pkg::PH_ALIGN: begin
        phState_nxt = phaseHold ? serdes_port_pkg::PH_LOCK : serdes_port_pkg::PH_ALIGN;
      end
      serdes_port_pkg::PH_LOCK: begin
        phState_nxt = phaseHold ? serdes_port_pkg::PH_LOCK : serdes_port_pkg::PH_ALIGN;
      end
      default: begin
        phState_nxt = serdes_port_pkg::PH_ALIGN;
      end
    endcase
  end
  wire locked = (phState_r == serdes_port_pkg::PH_LOCK);
  wire pathOpen = locked || !useTxClk;
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      phState_r <= serdes_port_pkg::PH_ALIGN;
      phaseCnt_r <= 8'h00;
      phaseOffset_r <= 8'h00;
    end else begin
      phState_r <= phState_nxt;
      phaseCnt_r <= charTick ? 8'h00 : phaseCnt_r + 8'h01;
      if (!locked && txClkRise) begin
        phaseOffset_r <= phaseCnt_r;
      end
    end
  end

  // ************************************************************
  // phase-align buffer
  // ************************************************************
  logic [9:0] fifoOutData;
  logic fifoOutValid;
  logic fifoInReady;
  wire fifoPush = captureEdge && pathOpen;
  wire fifoPop = charTick && pathOpen && txEncoderReady && fifoOutValid;
  assign txBufferReady = fifoInReady;

  char_fifo #(
    .WIDTH(serdes_port_pkg::CHAR_WIDTH),
    .DEPTH(serdes_port_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk(mclk),
    .rst(sys_rst),
    .flush(!pathOpen),
    .inData(txPinSync_r),
    .inValid(fifoPush),
    .inReady(fifoInReady),
    .outData(fifoOutData),
    .outValid(fifoOutValid),
    .outReady(fifoPop)
  );

  logic [9:0] txCharOut_r;
  logic txCharValid_r;
  logic [2:0] synthCnt_r;
  logic synthClk_r;
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      txCharOut_r <= 10'h000;
      txCharValid_r <= 1'b0;
      overflow_r <= 1'b0;
      synthCnt_r <= 3'h0;
      synthClk_r <= 1'b0;
    end else begin
      txCharValid_r <= fifoPop;
      if (fifoPop) begin
        txCharOut_r <= fifoOutData;
      end
      overflow_r <= (fifoPush && !fifoInReady) || (overflow_r && !clearOverflow);
      synthCnt_r <= charTick ? serdes_port_pkg::SYNTH_HIGH_CYC
                             : ((synthCnt_r != 3'h0) ? synthCnt_r - 3'h1 : 3'h0);
      synthClk_r <= charTick || (synthCnt_r > 3'h1);
    end
  end
  assign txCharOut = txCharOut_r;
  assign txCharValid = txCharValid_r;
  assign tx_synth_clock_out = synthClk_r;

  // ************************************************************
  // receive output staging
  // ************************************************************
  logic [9:0] pendRaw_r;
  logic pendComma_r;
  logic [7:0] pendData_r;
  logic [2:0] pendStat_r;
  logic pendValid_r;
  logic [7:0] rxData_r;
  logic [2:0] rxStat_r;
  logic rxClkOut_r;
  wire rxUseRef = (rxClkSel == serdes_port_pkg::LVL_LOW);
  wire rxSelRise = rxUseRef ? refRise : rxClkRise;
  wire rxUpdate = rxSelRise && pendValid_r;
  wire decBypass = (decoder_mode_select == serdes_port_pkg::LVL_LOW);
  wire [7:0] rxData_nxt = decBypass ? pendRaw_r[9:2] : pendData_r;
  wire [2:0] rxStat_nxt = decBypass ? {pendComma_r, pendRaw_r[1:0]} : pendStat_r;
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      pendRaw_r <= 10'h000;
      pendComma_r <= 1'b0;
      pendData_r <= 8'h00;
      pendStat_r <= 3'h0;
      pendValid_r <= 1'b0;
      rxData_r <= 8'h00;
      rxStat_r <= 3'h0;
      rxClkOut_r <= 1'b0;
    end else begin
      if (rxCharStrobe) begin
        pendRaw_r <= rxCharIn;
        pendComma_r <= rxCharComma;
        pendData_r <= rxDecodedData;
        pendStat_r <= rxDecodedStatus;
      end
      pendValid_r <= rxCharStrobe || (pendValid_r && !rxUpdate);
      if (rxUpdate) begin
        rxData_r <= rxData_nxt;
        rxStat_r <= rxStat_nxt;
      end
      rxClkOut_r <= rxUseRef ? refSync_r[1] : rxClkSync_r[1];
    end
  end
  assign rx_parallel_data = rxData_r;
  assign rx_char_status = rxStat_r;
  assign rx_char_clock_out = rxClkOut_r;

  // ************************************************************
  // register read
  // ************************************************************
  wire [31:0] statusWord = {8'h00, phaseOffset_r, 3'h0, txBitClockMult, modeIdx,
                            1'b0, locked, invalidCfg, overflow_r};
  wire [31:0] rxWord = {21'h000000, rxStat_r, rxData_r};
  wire rdMapped = (araddr == serdes_port_pkg::ADDR_CONFIG) ||
                  (araddr == serdes_port_pkg::ADDR_STATUS) ||
                  (araddr == serdes_port_pkg::ADDR_RXCHAR);
  wire [31:0] rdMux = (araddr == serdes_port_pkg::ADDR_CONFIG) ? config_r :
                      (araddr == serdes_port_pkg::ADDR_STATUS) ? statusWord :
                      (araddr == serdes_port_pkg::ADDR_RXCHAR) ? rxWord : 32'h0000_0000;
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= serdes_port_pkg::RESP_OKAY;
    end else if (arTake) begin
      rvalid_r <= 1'b1;
      rdata_r <= rdMux;
      rresp_r <= rdMapped ? serdes_port_pkg::RESP_OKAY : serdes_port_pkg::RESP_SLVERR;
    end else if (rready) begin
      rvalid_r <= 1'b0;
    end
  end

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  sequence s_rx_edge_with_char;
    pendValid_r && rxSelRise;
  endsequence
  sequence s_rx_bypass_edge;
    s_rx_edge_with_char ##0 decBypass;
  endsequence

  a_floating_mid: assert property ((config_r[1:0] == 2'h3) |-> (txClkSel == 2'h1))
    else $error("floating select not read as mid");
  a_mode_onehot: assert property ($onehot(txModeOneHot) && txModeOneHot[modeIdx])
    else $error("transmit mode decode not one of nine");
  a_invalid_fallback: assert property ((rateHigh && txClkSel != 2'h0) |-> !useTxClk)
    else $error("forbidden clock combination not refused");
  a_phase_frozen: assert property (locked && $past(locked) |-> $stable(phaseOffset_r))
    else $error("phase offset moved while held");
  a_phase_tracks: assert property ((!locked && txClkRise) |=>
    (phaseOffset_r == $past(phaseCnt_r))) else $error("phase offset not adjusted");
  a_half_rate_edges: assert property ((rateHigh && refFall) |-> charTick)
    else $error("falling reference edge ignored in half-rate mode");
  a_bit_clock_mult: assert property (txBitClockMult == (rateHigh ? 5'd20 : 5'd10))
    else $error("bit clock multiple wrong");
  a_tx_capture: assert property ((pathOpen && (useTxClk ? txClkRise : charTick)) |->
    fifoPush) else $error("input register missed its clock edge");
  a_no_dup_pop: assert property (txCharValid_r |->
    !$past(txCharValid_r) || $past(charTick, 1)) else $error("character passed twice");
  a_rx_only_edge: assert property ($changed(rxData_r) |-> $past(rxSelRise))
    else $error("receive data changed off the selected edge");
  a_rx_bypass_bits: assert property (s_rx_bypass_edge |=>
    (rx_parallel_data == $past(pendRaw_r[9:2]))) else $error("bypass data not upper raw bits");
  a_rx_decoded: assert property ((s_rx_edge_with_char ##0 !decBypass) |=>
                                 (rx_char_status == $past(pendStat_r)) &&
                                 (rx_parallel_data == $past(pendData_r)))
    else $error("decoded byte or status lost");
endmodule

/* serdes_port_pkg.sv */
// constants, encodings and field layout of the parallel host port clocking block
// assumes a single 100 MHz system clock and AXI4-Lite register access
// Functional notes
// - phase tracks while reset low, frozen when high
// - two ternary selects decode nine static modes
// - half-rate mode uses both reference clock edges
// - ternary selects read LOW/MID/HIGH, floating is MID
// - rx data change after selected clock rising edge
// - decoder on: byte or special, status tells
// - decoder bypassed: upper eight raw character bits
// - bit clock twenty or ten times reference
// - capture on reference or tx_input_clock per select
package serdes_port_pkg;
  // ************************************************************
  // register map
  // ************************************************************
  localparam logic [3:0] ADDR_CONFIG = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_RXCHAR = 4'h8;
  localparam logic [31:0] CONFIG_RESET = 32'h0000_0fb3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ************************************************************
  // config fields
  // ************************************************************
  localparam int CFG_TXCLKSEL_LSB = 0;
  localparam int CFG_RATE_BIT = 2;
  localparam int CFG_MODE0_LSB = 4;
  localparam int CFG_MODE1_LSB = 6;
  localparam int CFG_RXCLKSEL_LSB = 8;
  localparam int CFG_DECODER_MODE_SELECT_LSB = 10;
  localparam int CFG_PHRST_BIT = 12;
  localparam int CFG_USED_BITS = 13;
  // ************************************************************
  // status fields
  // ************************************************************
  localparam int ST_OVERFLOW_BIT = 0;
  localparam int ST_INVALID_BIT = 1;
  localparam int ST_LOCKED_BIT = 2;
  localparam int ST_MODE_LSB = 4;
  localparam int ST_MULT_LSB = 8;
  localparam int ST_PHASE_LSB = 16;
  // ************************************************************
  // ternary levels and sizes
  // ************************************************************
  localparam logic [1:0] LVL_LOW = 2'h0;
  localparam logic [1:0] LVL_MID = 2'h1;
  localparam logic [1:0] LVL_HIGH = 2'h2;
  localparam logic [1:0] LVL_FLOAT = 2'h3;
  localparam int MODE_COUNT = 9;
  localparam logic [4:0] MULT_HALF_RATE = 5'h14;
  localparam logic [4:0] MULT_FULL_RATE = 5'h0a;
  localparam int FIFO_DEPTH = 32;
  localparam int CHAR_WIDTH = 10;
  localparam logic [2:0] SYNTH_HIGH_CYC = 3'h3;
  localparam int PHASE_WIDTH = 8;

  typedef enum logic [1:0] {
    PH_ALIGN = 2'h1,
    PH_LOCK = 2'h2
  } phase_state_e;

  // floating code reads as the self-biased middle level
  function automatic logic [1:0] ternLevel(input logic [1:0] code);
    ternLevel = (code == LVL_FLOAT) ? LVL_MID : code;
  endfunction
endpackage

/* char_fifo.sv */
// small character fifo with registered output stage
// assumes one clock; both sides use valid/ready
`timescale 1ns/1ps
module char_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 32
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic flush,
  input wire logic [WIDTH-1:0] inData,
  input wire logic inValid,
  output logic inReady,
  output logic [WIDTH-1:0] outData,
  output logic outValid,
  input wire logic outReady
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr_r;
  logic [AW-1:0] rdPtr_r;
  logic [AW:0] count_r;
  logic [WIDTH-1:0] outData_r;
  logic outValid_r;
  wire push = inValid && inReady;
  wire load = (count_r != '0) && (!outValid_r || outReady);

  assign inReady = (count_r != DEPTH[AW:0]) && !flush;
  assign outData = outData_r;
  assign outValid = outValid_r;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wrPtr_r] <= inData;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      count_r <= '0;
      outValid_r <= 1'b0;
      outData_r <= '0;
    end else if (flush) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      count_r <= '0;
      outValid_r <= 1'b0;
    end else begin
      if (push) begin
        wrPtr_r <= wrPtr_r + 1'b1;
      end
      if (load) begin
        rdPtr_r <= rdPtr_r + 1'b1;
        outData_r <= mem[rdPtr_r];
        outValid_r <= 1'b1;
      end else if (outReady) begin
        outValid_r <= 1'b0;
      end
      count_r <= count_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, load};
    end
  end
endmodule

/* host_model.sv */
// host logic model: external clocks and a counting stream of tx characters
// assumes the bench sets halfRate and useTxClk to match the capture setup
`timescale 1ns/1ps
module host_model (
  input wire logic halfRate,
  input wire logic useTxClk,
  output logic reference_clock_in,
  output logic tx_input_clock,
  output logic rxRecoveredClock,
  output logic [7:0] tx_parallel_data,
  output logic [1:0] tx_char_control
);
  logic [9:0] cnt;
  assign {tx_char_control, tx_parallel_data} = cnt;
  initial begin
    reference_clock_in = 1'b0;
    tx_input_clock = 1'b0;
    rxRecoveredClock = 1'b0;
    cnt = 10'h000;
  end
  always #62.5 reference_clock_in = ~reference_clock_in;
  always #50 rxRecoveredClock = ~rxRecoveredClock;
  // same rate as the reference, fixed lag
  always @(reference_clock_in) tx_input_clock <= #40 reference_clock_in;
  // next character well after each capture edge
  always @(posedge reference_clock_in) if (!useTxClk) cnt <= #30 cnt + 10'h001;
  always @(negedge reference_clock_in) if (!useTxClk && halfRate) cnt <= #30 cnt + 10'h001;
  always @(posedge tx_input_clock) if (useTxClk) cnt <= #30 cnt + 10'h001;
endmodule

/* tb.sv */
// self-checking bench for the parallel port clocking block
// assumes host_model supplies the external clocks and tx characters
`timescale 1ns/1ps
module tb;
  logic mclk, sys_rst, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready;
  logic rvalid, rready, txBufferReady, txCharValid, txEncoderReady, rxCharComma, rxCharStrobe;
  logic rx_char_clock_out, tx_synth_clock_out, reference_clock_in, tx_input_clock;
  logic rxRecoveredClock, halfRate, useTxClk, havePrev, prevRck, watch;
  logic [3:0] awaddr, araddr, wstrb;
  logic [31:0] wdata, rdata, d, v;
  logic [1:0] bresp, rresp, r, tx_char_control, rxs, dec;
  logic [9:0] txCharOut, rxCharIn, prevTx;
  logic [7:0] tx_parallel_data, rxDecodedData, rx_parallel_data, prevRxd, rnd;
  logic [8:0] txModeOneHot;
  logic [4:0] txBitClockMult;
  logic [2:0] rxDecodedStatus, rx_char_status;
  int errors, compares, txCount, m;
  serdes_port_clocking serdes_port_clocking_i (.*);
  host_model host_model_i (.*);
  task automatic check(input string what, input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, e, s);
    end
  endtask
  task automatic stop_test();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic axiWrite(input logic [3:0] a, input logic [31:0] x);
    awaddr <= a;
    wdata <= x;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge mclk);
      if (awready && awvalid) awvalid <= 1'b0;
      if (wready && wvalid) wvalid <= 1'b0;
    end while (!bvalid);
    r = bresp;
  endtask
  task automatic axiRead(input logic [3:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge mclk);
      if (arready && arvalid) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    r = rresp;
  endtask
  // skip settling, then expect 40 gap-free characters
  task automatic runChars(input string what);
    watch = 1'b0;
    repeat (500) @(posedge mclk);
    havePrev = 1'b0;
    txCount = 0;
    watch = 1'b1;
    for (int n = 0; n < 9000 && txCount < 40; n++) @(posedge mclk);
    watch = 1'b0;
    check(what, 32'(txCount > 39), 32'h1);
    $display("test %s done", what);
  endtask
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  function automatic int lvl(input logic [1:0] c);
    return (c == 2'h3) ? 1 : int'(c);
  endfunction
  function automatic logic [31:0] cfg(input logic [1:0] t, m0, m1, rx, dc, input logic rt, ph);
    return {19'h0, ph, dc, rx, m1, m0, 1'b0, rt, t};
  endfunction
  always @(posedge mclk) begin
    #1;
    if (txCharValid === 1'b1 && watch) begin
      if (havePrev) check("tx order", 32'(txCharOut), 32'(prevTx + 10'h001));
      prevTx = txCharOut;
      havePrev = 1'b1;
      txCount++;
    end
    if (!sys_rst && rx_parallel_data !== prevRxd)
      check("rx edge", 32'({prevRck, rx_char_clock_out}), 32'h1);
    prevRxd = rx_parallel_data;
    prevRck = rx_char_clock_out;
  end
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // whole run needs well under 20000 cycles
  initial begin
    #500000;
    errors++;
    stop_test();
  end
  initial begin
    sys_rst = 1'b1;
    {awvalid, wvalid, arvalid, rxCharComma, rxCharStrobe} = '0;
    {bready, rready} = 2'h3;
    {awaddr, araddr, wdata, rxCharIn, rxDecodedData, rxDecodedStatus, prevRxd} = '0;
    {halfRate, useTxClk, watch} = '0;
    wstrb = 4'hf;
    txEncoderReady = 1'b1;
    repeat (20) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    axiRead(serdes_port_pkg::ADDR_CONFIG);
    check("config reset", d, serdes_port_pkg::CONFIG_RESET);
    axiRead(4'hc);
    check("unmapped", 32'(r), 32'(serdes_port_pkg::RESP_SLVERR));
    axiWrite(serdes_port_pkg::ADDR_RXCHAR, 32'h0000_00ff);
    check("read-only", 32'(r), 32'(serdes_port_pkg::RESP_SLVERR));
    $display("test registers done");
    for (int i = 0; i < 16; i++) begin
      v = cfg(i[3:2], i[1:0], i[3:2], 2'h0, 2'h0, i[0], 1'b0);
      axiWrite(serdes_port_pkg::ADDR_CONFIG, v | 32'hffff_e000);
      axiRead(serdes_port_pkg::ADDR_CONFIG);
      check("config rw", d, v);
      axiRead(serdes_port_pkg::ADDR_STATUS);
      m = lvl(i[3:2]) * 3 + lvl(i[1:0]);
      check("one-hot", 32'(txModeOneHot), 32'h1 << m);
      check("mode index", 32'(d[7:4]), 32'(m));
      check("bit clock", 32'(d[12:8]), i[0] ? 32'h14 : 32'h0a);
      check("bad combo", 32'(d[1]), 32'(i[0] && i[3:2] != 2'h0));
    end
    $display("test modes done");
    rnd = 8'h5f;
    for (int k = 0; k < 9; k++) begin
      rxs = (k < 5) ? serdes_port_pkg::LVL_LOW : serdes_port_pkg::LVL_MID;
      dec = 2'(k % 3);
      axiWrite(serdes_port_pkg::ADDR_CONFIG, cfg(2'h0, 2'h0, 2'h0, rxs, dec, 1'b0, 1'b0));
      rnd = lfsr(rnd);
      rxCharIn <= {rnd, ~rnd[1:0]};
      rxCharComma <= rnd[0];
      rxDecodedData <= ~rnd;
      rxDecodedStatus <= rnd[3:1];
      rxCharStrobe <= 1'b1;
      @(posedge mclk);
      rxCharStrobe <= 1'b0;
      repeat (2) @(posedge rx_char_clock_out);
      @(posedge mclk);
      axiRead(serdes_port_pkg::ADDR_RXCHAR);
      v = (dec == 2'h0) ? {21'h0, rnd[0], ~rnd[1:0], rnd} : {21'h0, rnd[3:1], ~rnd};
      check("rx char", d, v);
      check("rx pins", 32'({rx_char_status, rx_parallel_data}), v);
    end
    $display("test receive done");
    v = cfg(serdes_port_pkg::LVL_LOW, 2'h0, 2'h0, 2'h0, 2'h0, 1'b0, 1'b0);
    axiWrite(serdes_port_pkg::ADDR_CONFIG, v);
    runChars("reference path");
    halfRate <= 1'b1;
    axiWrite(serdes_port_pkg::ADDR_CONFIG, v | 32'h4);
    runChars("half rate");
    halfRate <= 1'b0;
    useTxClk <= 1'b1;
    v = cfg(serdes_port_pkg::LVL_HIGH, 2'h0, 2'h0, 2'h0, 2'h0, 1'b0, 1'b0);
    axiWrite(serdes_port_pkg::ADDR_CONFIG, v);
    repeat (100) @(posedge mclk);
    axiRead(serdes_port_pkg::ADDR_STATUS);
    check("tracking", 32'(d[2]), 32'h0);
    axiWrite(serdes_port_pkg::ADDR_CONFIG, v | 32'h1000);
    axiRead(serdes_port_pkg::ADDR_STATUS);
    check("locked", 32'(d[2]), 32'h1);
    runChars("input clock path");
    txEncoderReady <= 1'b0;
    for (int n = 0; n < 9000 && txBufferReady !== 1'b0; n++) @(posedge mclk);
    repeat (50) @(posedge mclk);
    axiRead(serdes_port_pkg::ADDR_STATUS);
    check("overflow", 32'(d[0]), 32'h1);
    txEncoderReady <= 1'b1;
    runChars("after stall");
    axiWrite(serdes_port_pkg::ADDR_STATUS, 32'h1);
    axiRead(serdes_port_pkg::ADDR_STATUS);
    check("overflow clear", 32'(d[0]), 32'h0);
    stop_test();
  end
endmodule
